/* File: hdl/bwc_pkg.sv */
/*
 * bwc_pkg: constants and carrier types of the bridge window
 * configuration register bank.
 * assumes: configuration accesses are dword addressed with byte enables.
 */
`default_nettype none

package bwc_pkg;

    // ========================================================
    // register byte offsets in configuration space
    localparam logic [7:0] OFF_PF_TOP_HI    = 8'h2c;
    localparam logic [7:0] OFF_IO_BOTTOM_HI = 8'h30;
    localparam logic [7:0] OFF_IO_TOP_HI    = 8'h32;
    localparam logic [7:0] OFF_CAP_PTR      = 8'h34;
    localparam logic [7:0] OFF_IRQ_LINE     = 8'h3c;
    localparam logic [7:0] OFF_IRQ_PIN      = 8'h3d;

    // ========================================================
    // reset and hardwired values
    localparam logic [31:0] PF_TOP_HI_RST    = 32'h0000_0000;
    localparam logic [15:0] IO_BOTTOM_RST    = 16'h0000;
    localparam logic [15:0] IO_TOP_RST       = 16'h0000;
    localparam logic [7:0]  CAP_PTR_VAL      = 8'h50;
    localparam logic [7:0]  IRQ_LINE_RST     = 8'hff;
    localparam logic [7:0]  IRQ_PIN_VAL      = 8'h00;
    localparam logic [31:0] RDATA_RST        = 32'h0000_0000;

    // ========================================================
    // implied low and padding address bits of window bounds, secondary interrupt width
    localparam logic [19:0] LOW_BITS_ZERO    = 20'h00000;
    localparam logic [19:0] LOW_BITS_ONES    = 20'hfffff;
    localparam logic [27:0] IO_PAD_ZERO      = 28'h0000000;
    localparam int          SEC_INT_W        = 4;

    // ========================================================
    // carrier types
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [7:2]  dw;
        logic [3:0]  be;
        logic [31:0] wdata;
    } bwc_cfg_req_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] rdata;
    } bwc_cfg_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [63:0] addr;
    } bwc_txn_t;

    typedef struct packed {
        logic valid;
        logic hit;
    } bwc_fwd_t;

endpackage : bwc_pkg

`default_nettype wire

/* File: hdl/bwc_range_match.sv */
/*
 * bwc_range_match: inclusive 64-bit address window compare.
 * assumes: bounds are already expanded with their implied low bits.
 */
`timescale 1ns/1ps
`default_nettype none

module bwc_range_match
(
    // window bounds
    input  wire logic [63:0] lo_i,
    input  wire logic [63:0] hi_i,
    // address under test
    input  wire logic [63:0] addr_i,
    // result
    output logic             hit_o
);

    // ========================================================
    // inclusive compare, empty when lo above hi
    assign hit_o = (addr_i >= lo_i) && (addr_i <= hi_i);

endmodule // bwc_range_match

`default_nettype wire

/* File: hdl/bwc_window_regs.sv */
/*
 * bwc_window_regs: upper prefetchable limit, upper I/O base and
 * limit, capability pointer and interrupt line/pin registers of a
 * bridge header, plus downstream forward decisions.
 * assumes: one core clock; the prefetch base and the lower prefetch limit half come from outside.
 */
// Contract
// - 32-bit RW upper prefetch limit at 2Ch, reset 0
// - prefetch window decides downstream memory forwarding
// - 16-bit RW upper I/O base at 30h
// - I/O base low 20 bits are zeros
// - 16-bit RW upper I/O limit at 32h
// - I/O limit low 20 bits are ones
// - forward I/O only inside base..limit range
// - capability pointer at 34h reads 50h
// - interrupt line at 3Ch resets to FFh
// - interrupt line is plain storage only
// - interrupt pin at 3Dh reads 00h
// - pass secondary interrupts to primary side
// - upper limit forms window limit bits 63:32
// - prefetch limit low 20 bits are ones
`timescale 1ns/1ps
`default_nettype none

module bwc_window_regs
(
    // clock and reset
    input  wire logic                  CLK_I,
    input  wire logic                  ARST_N_I,
    // configuration access
    input  wire bwc_pkg::bwc_cfg_req_t CFG_REQ_I,
    output bwc_pkg::bwc_cfg_rsp_t      CFG_RSP_O,
    // prefetch base and lower prefetch limit half held elsewhere
    input  wire logic [31:0]           PF_BASE_HI_I,
    input  wire logic [11:0]           PF_BASE_LO_I,
    input  wire logic [11:0]           PF_TOP_LO_I,
    // transactions seen on the primary side
    input  wire bwc_pkg::bwc_txn_t     MEM_TXN_I,
    input  wire bwc_pkg::bwc_txn_t     IO_TXN_I,
    // forward decisions
    output bwc_pkg::bwc_fwd_t          MEM_FWD_O,
    output bwc_pkg::bwc_fwd_t          IO_FWD_O,
    // window values for the forwarding path
    output logic [31:0]                PF_TOP_HI_O,
    output logic [15:0]                IO_BOTTOM_HI_O,
    output logic [15:0]                IO_TOP_HI_O,
    // interrupt pass-through, active low
    input  wire logic [3:0]            SEC_INT_N_I,
    output logic [3:0]                 PRI_INT_N_O
);

    import bwc_pkg::*;

    // ========================================================
    // helpers
    // dword match of a byte offset
    function automatic logic dw_hit(input logic [7:2] dw,
                                    input logic [7:0] off);
        dw_hit = (dw == off[7:2]);
    endfunction

    // byte-lane merge of a write into a stored word
    function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0]  be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++)
        begin
            if (be[i])
            begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        lane_merge = res;
    endfunction

    // ========================================================
    // storage
    logic [31:0]  pf_top_q;
    logic [31:0]  pf_top_d;
    logic [15:0]  io_bottom_q;
    logic [15:0]  io_bottom_d;
    logic [15:0]  io_top_q;
    logic [15:0]  io_top_d;
    logic [7:0]   irq_line_q;
    logic [7:0]   irq_line_d;
    bwc_cfg_rsp_t rsp_q;
    bwc_cfg_rsp_t rsp_d;
    logic [31:0]  io_word;
    logic [31:0]  io_merged;
    logic [7:0]   line_lane;
    logic [7:0]   pin_lane;

    // ========================================================
    // register write path
    always_comb
    begin
        pf_top_d    = pf_top_q;
        io_bottom_d = io_bottom_q;
        io_top_d    = io_top_q;
        irq_line_d  = irq_line_q;
        io_word     = {io_top_q, io_bottom_q};
        io_merged   = lane_merge(io_word, CFG_REQ_I.wdata, CFG_REQ_I.be);
        if (CFG_REQ_I.wr)
        begin
            if (dw_hit(CFG_REQ_I.dw, OFF_PF_TOP_HI))
            begin
                pf_top_d = lane_merge(pf_top_q, CFG_REQ_I.wdata,
                                      CFG_REQ_I.be);
            end
            else if (dw_hit(CFG_REQ_I.dw, OFF_IO_BOTTOM_HI))
            begin
                io_bottom_d = io_merged[15:0];
                io_top_d    = io_merged[31:16];
            end
            else if (dw_hit(CFG_REQ_I.dw, OFF_IRQ_LINE))
            begin
                // only lane 0 is stored; the pin lane is read-only
                if (CFG_REQ_I.be[0])
                begin
                    irq_line_d = CFG_REQ_I.wdata[7:0];
                end
            end
            // capability pointer dword has no storage at all
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            pf_top_q    <= PF_TOP_HI_RST;
            io_bottom_q <= IO_BOTTOM_RST;
            io_top_q    <= IO_TOP_RST;
            irq_line_q  <= IRQ_LINE_RST;
        end
        else
        begin
            pf_top_q    <= pf_top_d;
            io_bottom_q <= io_bottom_d;
            io_top_q    <= io_top_d;
            irq_line_q  <= irq_line_d;
        end
    end

    // ========================================================
    // read path, answered one cycle after the request
    always_comb
    begin
        rsp_d.valid = CFG_REQ_I.rd;
        rsp_d.rdata = RDATA_RST;
        line_lane   = irq_line_q;
        pin_lane    = IRQ_PIN_VAL;
        if (CFG_REQ_I.rd)
        begin
            if (dw_hit(CFG_REQ_I.dw, OFF_PF_TOP_HI))
            begin
                rsp_d.rdata = pf_top_q;
            end
            else if (dw_hit(CFG_REQ_I.dw, OFF_IO_BOTTOM_HI))
            begin
                rsp_d.rdata = {io_top_q, io_bottom_q};
            end
            else if (dw_hit(CFG_REQ_I.dw, OFF_CAP_PTR))
            begin
                rsp_d.rdata = {24'h000000, CAP_PTR_VAL};
            end
            else if (dw_hit(CFG_REQ_I.dw, OFF_IRQ_LINE))
            begin
                rsp_d.rdata = {16'h0000, pin_lane, line_lane};
            end
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            rsp_q <= '0;
        end
        else
        begin
            rsp_q <= rsp_d;
        end
    end

    // ========================================================
    // window bounds with implied low bits
    logic [63:0] pf_lo;
    logic [63:0] pf_hi;
    logic [63:0] io_lo;
    logic [63:0] io_hi;
    logic        mem_hit;
    logic        io_hit;

    assign pf_lo = {PF_BASE_HI_I, PF_BASE_LO_I, LOW_BITS_ZERO};
    assign pf_hi = {pf_top_q, PF_TOP_LO_I, LOW_BITS_ONES};
    assign io_lo = {IO_PAD_ZERO, io_bottom_q, LOW_BITS_ZERO};
    assign io_hi = {IO_PAD_ZERO, io_top_q, LOW_BITS_ONES};

    // memory and I/O window compares
    bwc_range_match u_mem_match
    (
        .lo_i   (pf_lo),
        .hi_i   (pf_hi),
        .addr_i (MEM_TXN_I.addr),
        .hit_o  (mem_hit)
    );

    bwc_range_match u_io_match
    (
        .lo_i   (io_lo),
        .hi_i   (io_hi),
        .addr_i (IO_TXN_I.addr),
        .hit_o  (io_hit)
    );

    // ========================================================
    // forward decisions and interrupt pass-through
    bwc_fwd_t   mem_fwd_q;
    bwc_fwd_t   mem_fwd_d;
    bwc_fwd_t   io_fwd_q;
    bwc_fwd_t   io_fwd_d;
    logic [3:0] int_q;
    logic [3:0] int_d;

    always_comb
    begin
        mem_fwd_d.valid = MEM_TXN_I.valid;
        mem_fwd_d.hit   = MEM_TXN_I.valid && mem_hit;
        io_fwd_d.valid  = IO_TXN_I.valid;
        io_fwd_d.hit    = IO_TXN_I.valid && io_hit;
        int_d           = SEC_INT_N_I;
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            mem_fwd_q <= '0;
            io_fwd_q  <= '0;
            int_q     <= 4'hf; // all lines idle high
        end
        else
        begin
            mem_fwd_q <= mem_fwd_d;
            io_fwd_q  <= io_fwd_d;
            int_q     <= int_d;
        end
    end

    // ========================================================
    // outputs, all from flip-flops
    assign CFG_RSP_O      = rsp_q;
    assign MEM_FWD_O      = mem_fwd_q;
    assign IO_FWD_O       = io_fwd_q;
    assign PF_TOP_HI_O    = pf_top_q;
    assign IO_BOTTOM_HI_O = io_bottom_q;
    assign IO_TOP_HI_O    = io_top_q;
    assign PRI_INT_N_O    = int_q;

    // ========================================================
    // assertions
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!ARST_N_I);

    a_pf_top_write: assert property (
        CFG_REQ_I.wr && CFG_REQ_I.be == 4'hf
        && dw_hit(CFG_REQ_I.dw, OFF_PF_TOP_HI)
        |=> PF_TOP_HI_O == $past(CFG_REQ_I.wdata))
        else $error("upper prefetch limit not written");

    a_io_bottom_write: assert property (
        CFG_REQ_I.wr && CFG_REQ_I.be[1:0] == 2'h3
        && dw_hit(CFG_REQ_I.dw, OFF_IO_BOTTOM_HI)
        |=> IO_BOTTOM_HI_O == $past(CFG_REQ_I.wdata[15:0]))
        else $error("upper I/O base not written");

    a_io_top_write: assert property (
        CFG_REQ_I.wr && CFG_REQ_I.be[3:2] == 2'h3
        && dw_hit(CFG_REQ_I.dw, OFF_IO_TOP_HI)
        |=> IO_TOP_HI_O == $past(CFG_REQ_I.wdata[31:16]))
        else $error("upper I/O limit not written");

    a_cap_ptr_read: assert property (
        CFG_REQ_I.rd && dw_hit(CFG_REQ_I.dw, OFF_CAP_PTR)
        |=> CFG_RSP_O.valid && CFG_RSP_O.rdata == 32'h0000_0050)
        else $error("capability pointer not 50h");

    a_irq_line_back: assert property (
        CFG_REQ_I.wr && CFG_REQ_I.be[0]
        && dw_hit(CFG_REQ_I.dw, OFF_IRQ_LINE)
        ##1 CFG_REQ_I.rd && !CFG_REQ_I.wr
        && dw_hit(CFG_REQ_I.dw, OFF_IRQ_LINE)
        |=> CFG_RSP_O.rdata[7:0] == $past(CFG_REQ_I.wdata[7:0], 2))
        else $error("interrupt line not read back");

    a_irq_pin_zero: assert property (
        CFG_REQ_I.rd && dw_hit(CFG_REQ_I.dw, OFF_IRQ_PIN)
        |=> CFG_RSP_O.rdata[15:8] == 8'h00)
        else $error("interrupt pin not zero");

    a_mem_fwd_hit: assert property (
        MEM_TXN_I.valid
        |=> MEM_FWD_O.valid && MEM_FWD_O.hit
        == $past(MEM_TXN_I.addr >= pf_lo && MEM_TXN_I.addr <= pf_hi))
        else $error("memory forward decision wrong");

    a_io_fwd_hit: assert property (
        IO_TXN_I.valid
        |=> IO_FWD_O.valid && IO_FWD_O.hit
        == $past(IO_TXN_I.addr >= io_lo && IO_TXN_I.addr <= io_hi))
        else $error("I/O forward decision wrong");

    a_irq_pass_through: assert property (
        ##1 PRI_INT_N_O == $past(SEC_INT_N_I))
        else $error("secondary interrupt not passed");

    a_ro_write_kept: assert property (
        CFG_REQ_I.wr && dw_hit(CFG_REQ_I.dw, OFF_CAP_PTR)
        |=> $stable(PF_TOP_HI_O) && $stable(IO_BOTTOM_HI_O)
        && $stable(IO_TOP_HI_O))
        else $error("read-only write changed state");

endmodule // bwc_window_regs

`default_nettype wire

/* File: tb/bwc_host_model.sv */
/*
 * bwc_host_model: host issuing configuration reads and writes.
 * assumes: requests launched at the falling edge, one-cycle strobes.
 */
`timescale 1ns/1ps
`default_nettype none

module bwc_host_model
(
    // clock
    input  wire logic                  clk_i,
    // configuration bus
    output bwc_pkg::bwc_cfg_req_t      req_o,
    input  wire bwc_pkg::bwc_cfg_rsp_t rsp_i
);
    import bwc_pkg::*;

    logic [31:0] last_wd;

    // ========================================================
    // bus idle: strobes low, stale data inverted
    task automatic idle();
        req_o.rd    = 1'b0;
        req_o.wr    = 1'b0;
        req_o.wdata = ~last_wd;
    endtask

    initial
    begin
        last_wd = 32'h0;
        req_o   = '0;
    end

    // software programs the window and line registers
    task automatic cfg_wr(input logic [7:0] off, input logic [3:0] be,
                          input logic [31:0] wd);
        @(negedge clk_i);
        req_o.wr    = 1'b1;
        req_o.dw    = off[7:2];
        req_o.be    = be;
        req_o.wdata = wd;
        last_wd     = wd;
        @(negedge clk_i);
        idle();
    endtask

    // read, answer awaited a bounded number of cycles
    task automatic cfg_rd(input logic [7:0] off, output logic [31:0] d);
        int n;
        n = 0;
        @(negedge clk_i);
        req_o.rd = 1'b1;
        req_o.dw = off[7:2];
        req_o.be = 4'hf;
        @(negedge clk_i);
        idle();
        while (rsp_i.valid !== 1'b1 && n < 4)
        begin
            @(negedge clk_i);
            n++;
        end
        d = (rsp_i.valid === 1'b1) ? rsp_i.rdata : 32'hx;
    endtask

    // write, then read the same dword on the very next edge
    task automatic cfg_wr_rd(input logic [7:0] off, input logic [3:0] be,
                             input logic [31:0] wd,
                             output logic [31:0] d);
        @(negedge clk_i);
        req_o.wr    = 1'b1;
        req_o.dw    = off[7:2];
        req_o.be    = be;
        req_o.wdata = wd;
        last_wd     = wd;
        @(negedge clk_i);
        req_o.wr    = 1'b0;
        req_o.rd    = 1'b1;
        @(negedge clk_i);
        idle();
        d = (rsp_i.valid === 1'b1) ? rsp_i.rdata : 32'hx;
    endtask
endmodule // bwc_host_model

`default_nettype wire

/* File: tb/tb.sv */
/*
 * tb: register and forwarding checks of the window register bank.
 * assumes: inputs driven at the falling edge, 5 ns clock.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    miscompares++; $display("BAD %s exp %0h got %0h", nm, e, g); end end

module tb;
    import bwc_pkg::*;

    logic         CLK_I;
    logic         ARST_N_I;
    bwc_cfg_req_t req;
    bwc_cfg_rsp_t rsp;
    logic [31:0]  PF_BASE_HI_I;
    logic [11:0]  PF_BASE_LO_I;
    logic [11:0]  PF_TOP_LO_I;
    bwc_txn_t     MEM_TXN_I;
    bwc_txn_t     IO_TXN_I;
    bwc_fwd_t     mem_fwd;
    bwc_fwd_t     io_fwd;
    logic [31:0]  pf_top;
    logic [15:0]  io_bot;
    logic [15:0]  io_top;
    logic [3:0]   SEC_INT_N_I;
    logic [3:0]   pri_int_n;
    logic [31:0]  d;
    int           miscompares;
    int           comparisons;

    bwc_window_regs bwc_window_regs_i (
        .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .CFG_REQ_I(req),
        .CFG_RSP_O(rsp), .PF_BASE_HI_I(PF_BASE_HI_I),
        .PF_BASE_LO_I(PF_BASE_LO_I), .PF_TOP_LO_I(PF_TOP_LO_I),
        .MEM_TXN_I(MEM_TXN_I), .IO_TXN_I(IO_TXN_I),
        .MEM_FWD_O(mem_fwd), .IO_FWD_O(io_fwd), .PF_TOP_HI_O(pf_top),
        .IO_BOTTOM_HI_O(io_bot), .IO_TOP_HI_O(io_top),
        .SEC_INT_N_I(SEC_INT_N_I), .PRI_INT_N_O(pri_int_n));

    bwc_host_model bwc_host_model_i (
        .clk_i(CLK_I), .req_o(req), .rsp_i(rsp));

    // ========================================================
    // clock and closing
    always #2.5 CLK_I = ~CLK_I;

    task automatic complete_run();
        $display("comparisons %0d miscompares %0d", comparisons,
                 miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // read one register and compare
    task automatic rchk(input logic [7:0] off, input logic [31:0] e);
        bwc_host_model_i.cfg_rd(off, d);
        `CHK("cfg read", e, d)
    endtask

    // one transaction through a window, hit compared
    task automatic fwd(input logic io, input logic [63:0] a,
                       input logic e);
        @(negedge CLK_I);
        if (io) IO_TXN_I = '{1'b1, a};
        else    MEM_TXN_I = '{1'b1, a};
        @(negedge CLK_I);
        IO_TXN_I.valid  = 1'b0;
        MEM_TXN_I.valid = 1'b0;
        `CHK("forward", {1'b1, e}, io ? io_fwd : mem_fwd)
    endtask

    // watchdog
    initial
    begin
        #20000;
        miscompares++;
        complete_run();
    end

    // ========================================================
    // main sequence
    initial
    begin
        CLK_I = 1'b0; ARST_N_I = 1'b0; miscompares = 0; comparisons = 0;
        PF_BASE_HI_I = 32'h0; PF_BASE_LO_I = 12'h001;
        PF_TOP_LO_I = 12'h002; MEM_TXN_I = '0; IO_TXN_I = '0;
        SEC_INT_N_I = 4'hf;
        repeat (20) @(negedge CLK_I);
        ARST_N_I = 1'b1;
        // reset values and hardwired registers
        rchk(8'h2c, 32'h0);
        rchk(8'h30, 32'h0);
        rchk(8'h34, 32'h0000_0050);
        bwc_host_model_i.cfg_rd(8'h3c, d);
        `CHK("line pin", 16'h00ff, d[15:0])
        rchk(8'h40, 32'h0);
        // upper prefetch limit storage
        bwc_host_model_i.cfg_wr(8'h2c, 4'hf, 32'ha5c3_0f81);
        rchk(8'h2c, 32'ha5c3_0f81);
        `CHK("pf top", 32'ha5c3_0f81, pf_top)
        // i/o halves written lane by lane
        bwc_host_model_i.cfg_wr(8'h30, 4'h3, 32'hdead_0001);
        bwc_host_model_i.cfg_wr(8'h30, 4'hc, 32'h0002_beef);
        rchk(8'h30, 32'h0002_0001);
        `CHK("io bot", 16'h0001, io_bot)
        `CHK("io top", 16'h0002, io_top)
        // read-only places ignore writes
        bwc_host_model_i.cfg_wr(8'h34, 4'hf, 32'hffff_ffff);
        rchk(8'h34, 32'h0000_0050);
        bwc_host_model_i.cfg_wr(8'h3c, 4'hf, 32'hffff_a55a);
        bwc_host_model_i.cfg_rd(8'h3c, d);
        `CHK("line pin", 16'h005a, d[15:0])
        // back-to-back write and read of the line register
        bwc_host_model_i.cfg_wr_rd(8'h3c, 4'h1, 32'h0000_0033, d);
        `CHK("line b2b", 16'h0033, d[15:0])
        // interrupt pass-through unaffected by the line value
        @(negedge CLK_I);
        SEC_INT_N_I = 4'h5;
        @(negedge CLK_I);
        `CHK("pri int", 4'h5, pri_int_n)
        // i/o window boundaries
        fwd(1'b1, 64'h0000_0000_000f_ffff, 1'b0);
        fwd(1'b1, 64'h0000_0000_0010_0000, 1'b1);
        fwd(1'b1, 64'h0000_0000_002f_ffff, 1'b1);
        fwd(1'b1, 64'h0000_0000_0030_0000, 1'b0);
        // prefetch window boundaries with upper limit 1
        bwc_host_model_i.cfg_wr(8'h2c, 4'hf, 32'h0000_0001);
        fwd(1'b0, 64'h0000_0000_000f_ffff, 1'b0);
        fwd(1'b0, 64'h0000_0000_0010_0000, 1'b1);
        fwd(1'b0, 64'h0000_0001_002f_ffff, 1'b1);
        fwd(1'b0, 64'h0000_0001_0030_0000, 1'b0);
        complete_run();
    end
endmodule // tb

`default_nettype wire
